// [prescaled_downcounter_regs.sv]
// Prescaler, down-counter, control registers and interrupts of the timer
//
// Overview of operation
// RQ1: Prescaler readable/writable, top bit reads zero
// RQ2: Counter read/write anytime, resets to all ones
// RQ3: Zero flag set on counter underflow
// RQ4: Only software clears the zero flag
// RQ5: Interrupt request when flag and enable set
// RQ6: Direction bit zero input, one push-pull output
// RQ7: Data bit drives pin or picks input mode
// RQ8: Run bit low holds prescaler, stops counter
// RQ9: Divide select taps prescaler, two to n
// RQ10: Control register resets to zero
// RQ11: Enabled request wakes from wait and stop
// RQ12: Prescaler counts source edges, reloads all ones
// RQ13: Counter write beats coincident decrement, no flag
// RQ14: Writing zero count or bit seven sets flag
// RQ15: Gated mode counts only while pin high
//
// The implementer's own choice: the Wishbone register port.
`include "timer_defs.svh"
module prescaled_downcounter_regs
    import timer_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [11:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    input wire logic timer_pin_i,
    output logic timer_pin_o,
    output logic timer_pin_oe_n,
    input wire logic wait_mode,
    input wire logic stop_mode,
    output logic timer_irq,
    output logic evt_irq,
    output logic wake
);

    // Bus state
    logic ack_q; // Acknowledge, one cycle per request
    logic [31:0] dat_r_q; // Read data latched on the same edge that raises the ack
    logic [7:0] rd_data; // Read mux
    logic req; // Live request
    logic wr_en; // Write takes effect at the ack edge
    logic presc_wr; // Write to the prescaler
    logic cnt_wr; // Write to the counter
    logic ctrl_wr; // Write to the control/status register
    logic stat_wr; // Write-one-to-clear on event status
    logic mask_wr; // Write to event mask

    // Timer state
    logic [6:0] presc_q; // Prescaler count
    logic [7:0] cnt_q; // Counter value
    logic zero_q; // Zero flag
    logic ien_q; // Zero interrupt enable
    logic dir_q; // Pin direction select
    logic dout_q; // Pin data / input mode select
    logic run_q; // Prescaler run
    div_sel_t div_q; // Divide select
    logic [3:0] div12_q; // Internal divide-by-twelve
    logic pin_lvl_q; // Level driven onto the pin
    logic oe_n_q; // Pin output enable, low while driving
    logic [1:0] stat_q; // Sticky event status
    logic [1:0] mask_q; // Event mask
    logic timer_irq_q; // Timer interrupt request
    logic evt_irq_q; // Masked event interrupt
    logic wake_q; // Low-power wake request

    // Derived signals
    mode_t mode; // Current prescaler source mode
    logic pin_level; // Synchronised pin level
    logic pin_rise; // Synchronised pin rising edge
    logic int_tick; // Internal f/12 tick
    logic src_tick; // Selected prescaler source edge
    logic presc_tick; // Prescaler decrement
    logic [6:0] tap_mask; // Low prescaler bits for the selected tap
    logic cnt_tick; // Counter decrement
    logic underflow; // Counter passes 00 to FF
    logic zero_set; // Any cause setting the zero flag
    logic presc_wrap; // Prescaler reloads after zero

    // Pin goes through two flops before any logic sees it
    pin_sync u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .pin_async(timer_pin_i),
        .level(pin_level),
        .rise(pin_rise)
    );

    // Decode of a live request and the writes it carries
    assign req = wb_cyc & wb_stb;
    assign wr_en = req & wb_we & ack_q & wb_sel[0];
    assign presc_wr = wr_en & (wb_adr[11:2] == `IDX_PRESC);
    assign cnt_wr = wr_en & (wb_adr[11:2] == `IDX_COUNT);
    assign ctrl_wr = wr_en & (wb_adr[11:2] == `IDX_CTRL);
    assign stat_wr = wr_en & (wb_adr[11:2] == `IDX_EVT_STATUS);
    assign mask_wr = wr_en & (wb_adr[11:2] == `IDX_EVT_MASK);

    // One-cycle ack; dropped the cycle after it was given
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    // Read mux; unmapped indexes read as zero
    always_comb begin
        rd_data = 8'h00;
        unique case (wb_adr[11:2])
            `IDX_PRESC: rd_data = {1'b0, presc_q}; // RQ1
            `IDX_COUNT: rd_data = cnt_q; // RQ2
            `IDX_CTRL: rd_data = {zero_q, ien_q, dir_q, dout_q, run_q, div_q};
            `IDX_EVT_STATUS: rd_data = {6'h00, stat_q};
            `IDX_EVT_MASK: rd_data = {6'h00, mask_q};
            default: rd_data = 8'h00;
        endcase
    end

    // Read data captured while the ack is being raised
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dat_r_q <= 32'h00000000;
        end else if (req & ~ack_q & ~wb_we) begin
            dat_r_q <= {24'h000000, rd_data};
        end
    end

    // Mode from direction and data bits
    always_comb begin
        if (dir_q) begin
            mode = MODE_OUTPUT; // RQ7
        end else if (dout_q) begin
            mode = MODE_GATED; // RQ7
        end else begin
            mode = MODE_EVENT;
        end
    end

    // Internal divide-by-twelve; frozen in stop mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            div12_q <= `DIV12_ZERO;
        end else if (stop_mode) begin
            div12_q <= div12_q;
        end else if (div12_q == `DIV12_LAST) begin
            div12_q <= `DIV12_ZERO;
        end else begin
            div12_q <= div12_q + 4'h1;
        end
    end

    assign int_tick = ~stop_mode & (div12_q == `DIV12_LAST);

    // Source select; only pin events keep counting in stop mode
    always_comb begin
        src_tick = 1'b0;
        unique case (mode)
            MODE_EVENT: src_tick = pin_rise; // RQ12
            MODE_GATED: src_tick = int_tick & pin_level; // RQ15
            MODE_OUTPUT: src_tick = int_tick; // RQ12
        endcase
    end

    assign presc_tick = run_q & src_tick; // RQ8
    assign presc_wrap = presc_tick & (presc_q == 7'h00) & ~presc_wr;

    // Tap n fires once every two to the n prescaler steps
    assign tap_mask = 7'((8'h01 << div_q) - 8'h01); // RQ9
    assign cnt_tick = presc_tick & ((presc_q & tap_mask) == 7'h00); // RQ9

    // Prescaler: held at all ones when stopped, else counts down
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= `RST_PRESC;
        end else if (!run_q) begin
            presc_q <= `RST_PRESC; // RQ8
        end else if (presc_wr) begin
            presc_q <= wb_dat_w[6:0]; // RQ1
        end else if (presc_tick) begin
            if (presc_q == 7'h00) begin
                presc_q <= `RST_PRESC; // RQ12
            end else begin
                presc_q <= presc_q - 7'h01; // RQ12
            end
        end
    end

    // A write always wins, so a coincident decrement is dropped
    assign underflow = run_q & cnt_tick & (cnt_q == 8'h00) & ~cnt_wr; // RQ13

    // Counter: written on the fly, wraps 00 to FF
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `RST_COUNT; // RQ2
        end else if (cnt_wr) begin
            cnt_q <= wb_dat_w[7:0]; // RQ13
        end else if (run_q & cnt_tick) begin
            cnt_q <= cnt_q - 8'h01; // RQ8
        end
    end

    // Every cause that sets the zero flag
    assign zero_set = underflow // RQ3
        | (cnt_wr & (wb_dat_w[7:0] == 8'h00)) // RQ14
        | (ctrl_wr & wb_dat_w[`CTRL_ZERO]); // RQ14

    // Zero flag: set beats a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_q <= 1'b0; // RQ10
        end else if (zero_set) begin
            zero_q <= 1'b1; // RQ3
        end else if (ctrl_wr) begin
            zero_q <= 1'b0; // RQ4
        end
    end

    // Control bits other than the flag
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ien_q <= 1'b0; // RQ10
            dir_q <= 1'b0; // RQ10
            dout_q <= 1'b0;
            run_q <= 1'b0; // RQ10
            div_q <= 3'h0; // RQ10
        end else if (ctrl_wr) begin
            ien_q <= wb_dat_w[`CTRL_IEN];
            dir_q <= wb_dat_w[`CTRL_DIR]; // RQ6
            dout_q <= wb_dat_w[`CTRL_DOUT];
            run_q <= wb_dat_w[`CTRL_RUN]; // RQ8
            div_q <= wb_dat_w[`CTRL_DIV_HI:`CTRL_DIV_LO]; // RQ9
        end
    end

    // Pin level latched from the data bit as the flag rises
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_lvl_q <= 1'b0;
        end else if (zero_set & ~zero_q) begin
            pin_lvl_q <= dout_q; // RQ7
        end
    end

    // Pin driver enable; push-pull only in output mode
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= ~dir_q; // RQ6
        end
    end

    // Sticky events, write one to clear, set wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= `RST_EVT;
        end else begin
            stat_q[`EVT_ZERO] <= (zero_set & ~zero_q) | (stat_q[`EVT_ZERO]
                & ~(stat_wr & wb_dat_w[`EVT_ZERO]));
            stat_q[`EVT_PWRAP] <= presc_wrap | (stat_q[`EVT_PWRAP]
                & ~(stat_wr & wb_dat_w[`EVT_PWRAP]));
        end
    end

    // Event mask
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `RST_EVT;
        end else if (mask_wr) begin
            mask_q <= wb_dat_w[1:0];
        end
    end

    // Interrupt and wake outputs, all registered
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_irq_q <= 1'b0;
            evt_irq_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            timer_irq_q <= zero_q & ien_q; // RQ5
            evt_irq_q <= |(stat_q & mask_q);
            wake_q <= (wait_mode | stop_mode) & zero_q & ien_q; // RQ11
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = dat_r_q;
    assign timer_pin_o = pin_lvl_q;
    assign timer_pin_oe_n = oe_n_q;
    assign timer_irq = timer_irq_q;
    assign evt_irq = evt_irq_q;
    assign wake = wake_q;

    // Checks

    sequence presc_read_s;
        req && !ack_q && !wb_we && (wb_adr[11:2] == `IDX_PRESC);
    endsequence

    presc_read_a: assert property ( // RQ1
        @(posedge ref_clk) disable iff (!rst_n)
        presc_read_s |=> wb_dat_r == {25'h0, $past(presc_q)})
        else $error("prescaler read data wrong");

    halt_presc_a: assert property ( // RQ8
        @(posedge ref_clk) disable iff (!rst_n)
        !run_q |=> presc_q == `RST_PRESC)
        else $error("prescaler not held while stopped");

    count_hold_a: assert property ( // RQ8
        @(posedge ref_clk) disable iff (!rst_n)
        (!run_q && !cnt_wr) |=> $stable(cnt_q))
        else $error("counter moved while stopped");

    underflow_flag_a: assert property ( // RQ3
        @(posedge ref_clk) disable iff (!rst_n)
        underflow |=> zero_q && (cnt_q == 8'hFF))
        else $error("underflow did not set flag");

    write_wins_a: assert property ( // RQ13
        @(posedge ref_clk) disable iff (!rst_n)
        (cnt_wr && wb_dat_w[7:0] != 8'h00 && !ctrl_wr && !zero_q)
        |=> cnt_q == $past(wb_dat_w[7:0]) && !zero_q)
        else $error("counter write lost or flag set");

    no_self_clear_a: assert property ( // RQ4
        @(posedge ref_clk) disable iff (!rst_n)
        (zero_q && !ctrl_wr) |=> zero_q)
        else $error("zero flag cleared by hardware");

    // Request follows flag and enable one cycle late
    irq_gate_a: assert property ( // RQ5
        @(posedge ref_clk) disable iff (!rst_n) !ien_q |=> !timer_irq)
        else $error("timer request while disabled");

    irq_raise_a: assert property ( // RQ5
        @(posedge ref_clk) disable iff (!rst_n)
        (zero_q && ien_q) |=> timer_irq)
        else $error("timer request missing");

    wake_stop_a: assert property ( // RQ11
        @(posedge ref_clk) disable iff (!rst_n)
        ((stop_mode || wait_mode) && zero_q && ien_q) |=> wake)
        else $error("no wake request");

    pin_drive_a: assert property ( // RQ6
        @(posedge ref_clk) disable iff (!rst_n)
        dir_q [*2] |-> !timer_pin_oe_n)
        else $error("pin not driven in output mode");

    sequence zero_rise_s;
        !zero_q && dout_q && !ctrl_wr ##1 zero_q;
    endsequence

    pin_level_a: assert property ( // RQ7
        @(posedge ref_clk) disable iff (!rst_n)
        zero_rise_s |-> timer_pin_o)
        else $error("pin level not latched");

    tap_one_a: assert property ( // RQ9
        @(posedge ref_clk) disable iff (!rst_n)
        (div_q == 3'h0 && presc_tick && !cnt_wr && cnt_q != 8'h00)
        |=> cnt_q == $past(cnt_q) - 8'h01)
        else $error("divide by one tap wrong");

    soft_set_a: assert property ( // RQ14
        @(posedge ref_clk) disable iff (!rst_n)
        (cnt_wr && wb_dat_w[7:0] == 8'h00) |=> zero_q)
        else $error("zero write did not set flag");

    gated_hold_a: assert property ( // RQ15
        @(posedge ref_clk) disable iff (!rst_n)
        (mode == MODE_GATED && !pin_level && run_q && !presc_wr)
        |=> $stable(presc_q))
        else $error("gated prescaler moved with pin low");

    reload_a: assert property ( // RQ12
        @(posedge ref_clk) disable iff (!rst_n)
        presc_wrap && run_q |=> presc_q == `RST_PRESC)
        else $error("prescaler reload wrong");

endmodule // prescaled_downcounter_regs

// [timer_defs.svh]
// Offsets, field positions, reset values and counts of the 8-bit timer
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// Register indexes; byte address on the bus is four times the index
`define IDX_PRESC 10'h0D2
`define IDX_COUNT 10'h0D3
`define IDX_CTRL 10'h0D4
`define IDX_EVT_STATUS 10'h0D5
`define IDX_EVT_MASK 10'h0D6

// Reset values
`define RST_PRESC 7'h7F
`define RST_COUNT 8'hFF
`define RST_CTRL 8'h00
`define RST_EVT 2'h0

// Control/status field positions
`define CTRL_ZERO 7
`define CTRL_IEN 6
`define CTRL_DIR 5
`define CTRL_DOUT 4
`define CTRL_RUN 3
`define CTRL_DIV_HI 2
`define CTRL_DIV_LO 0

// Event status and mask field positions
`define EVT_ZERO 0
`define EVT_PWRAP 1

// Internal clock divider: one tick every twelve reference clocks
`define DIV12_LAST 4'hB
`define DIV12_ZERO 4'h0

`endif

// [timer_pkg.sv]
// Types shared by the timer files
package timer_pkg;

    // Prescaler source mode, one-hot
    typedef enum logic [2:0] {
        MODE_EVENT = 3'b001,
        MODE_GATED = 3'b010,
        MODE_OUTPUT = 3'b100
    } mode_t;

    // Divide select field
    typedef logic [2:0] div_sel_t;

endpackage

// [pin_sync.sv]
// Two-stage synchroniser with rising-edge detect for the timer pin
module pin_sync (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic pin_async,
    output logic level,
    output logic rise
);

    logic meta_q; // First stage, read only by the second
    logic sync_q; // Second stage, safe to use
    logic prev_q; // Previous safe level for edge detect

    // Synchroniser chain and edge history
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            meta_q <= pin_async;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign level = sync_q;
    assign rise = sync_q & ~prev_q;

endmodule // pin_sync

// [testbench.sv]
// Self-checking bench for the timer register and interrupt block
`include "timer_defs.svh"
`define CHK(g, e) check_val(32'(g), 32'(e))
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Byte addresses: one register per 32-bit word
    localparam logic [11:0] A_PRESC = {`IDX_PRESC, 2'b00};
    localparam logic [11:0] A_COUNT = {`IDX_COUNT, 2'b00};
    localparam logic [11:0] A_CTRL = {`IDX_CTRL, 2'b00};
    localparam logic [11:0] A_STAT = {`IDX_EVT_STATUS, 2'b00};
    localparam logic [11:0] A_MASK = {`IDX_EVT_MASK, 2'b00};
    localparam logic [11:0] A_NONE = 12'hFFC; // Unmapped word
    logic ref_clk, rst_n, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [11:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r, rd;
    logic timer_pin_i, timer_pin_o, timer_pin_oe_n;
    logic wait_mode, stop_mode, timer_irq, evt_irq, wake;
    int failures, comparisons;
    int d;

    prescaled_downcounter_regs u_prescaled_downcounter_regs (
        .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .timer_pin_i(timer_pin_i), .timer_pin_o(timer_pin_o),
        .timer_pin_oe_n(timer_pin_oe_n), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .timer_irq(timer_irq), .evt_irq(evt_irq),
        .wake(wake)
    );

    // 40 MHz reference clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // Case equality so an unknown never counts as a match
    task automatic check_val(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // Summary line, verdict, end of run
    task automatic report_and_stop();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Classic Wishbone cycle; held until ack is sampled high
    task automatic bus(input logic we, input logic [11:0] adr,
                       input logic [7:0] dat, input logic [3:0] sel);
        @(posedge ref_clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= sel;
        wb_dat_w <= {24'h000000, dat};
        // Only the watchdog ends a wait for a silent slave
        do begin
            @(posedge ref_clk);
        end while (wb_ack !== 1'b1);
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] adr, input logic [7:0] dat);
        bus(1'b1, adr, dat, 4'hF);
    endtask

    task automatic rd_chk(input logic [11:0] adr, input logic [7:0] e);
        bus(1'b0, adr, 8'h00, 4'hF);
        `CHK(rd, {24'h000000, e});
    endtask

    // Clean pin pulses, long enough for the two-flop synchroniser
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            timer_pin_i <= 1'b1;
            repeat (4) @(posedge ref_clk);
            timer_pin_i <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
        repeat (4) @(posedge ref_clk);
    endtask

    // Bounded wait for the timer request
    task automatic wait_irq();
        int n;
        n = 0;
        while (timer_irq !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            n++;
        end
        `CHK(timer_irq, 1'b1);
    endtask

    // Hang guard, far beyond the expected run of a few thousand cycles
    initial begin
        repeat (50000) @(posedge ref_clk);
        failures++;
        report_and_stop();
    end

    initial begin
        failures = 0;
        comparisons = 0;
        rst_n = 1'b0;
        {wb_cyc, wb_stb, wb_we} = 3'h0;
        wb_adr = 12'h000;
        wb_sel = 4'h0;
        wb_dat_w = 32'h00000000;
        {timer_pin_i, wait_mode, stop_mode} = 3'h0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        // Reset values and idle outputs
        `CHK(timer_pin_oe_n, 1'b1);
        `CHK(timer_irq, 1'b0);
        rd_chk(A_PRESC, 8'h7F);
        rd_chk(A_COUNT, 8'hFF);
        rd_chk(A_CTRL, 8'h00);
        rd_chk(A_NONE, 8'h00);
        wr(A_PRESC, 8'h22);
        rd_chk(A_PRESC, 8'h7F);
        $display("test reset done");
        // Run on, event mode, pin idle so nothing counts
        wr(A_CTRL, 8'h08);
        wr(A_PRESC, 8'hD5);
        rd_chk(A_PRESC, 8'h55);
        wr(A_COUNT, 8'hA5);
        bus(1'b1, A_COUNT, 8'h11, 4'hE);
        rd_chk(A_COUNT, 8'hA5);
        $display("test access done");
        // Underflow: arrival at zero is not yet the flag
        wr(A_PRESC, 8'h10);
        wr(A_COUNT, 8'h02);
        pulse(2);
        rd_chk(A_COUNT, 8'h00);
        rd_chk(A_CTRL, 8'h08);
        rd_chk(A_PRESC, 8'h0E);
        pulse(1);
        rd_chk(A_COUNT, 8'hFF);
        rd_chk(A_CTRL, 8'h88);
        `CHK(timer_irq, 1'b0);
        repeat (50) @(posedge ref_clk);
        rd_chk(A_CTRL, 8'h88);
        wr(A_CTRL, 8'hC8);
        repeat (3) @(posedge ref_clk);
        `CHK(timer_irq, 1'b1);
        `CHK(wake, 1'b0);
        wait_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(wake, 1'b1);
        wait_mode <= 1'b0;
        stop_mode <= 1'b1;
        repeat (3) @(posedge ref_clk);
        `CHK(wake, 1'b1);
        stop_mode <= 1'b0;
        wr(A_CTRL, 8'h48);
        repeat (3) @(posedge ref_clk);
        `CHK(timer_irq, 1'b0);
        $display("test underflow done");
        // Software ways of setting the flag, and the event register
        wr(A_CTRL, 8'h08);
        wr(A_COUNT, 8'h00);
        rd_chk(A_CTRL, 8'h88);
        wr(A_STAT, 8'h03);
        rd_chk(A_STAT, 8'h00);
        wr(A_CTRL, 8'h08);
        wr(A_CTRL, 8'h88);
        rd_chk(A_CTRL, 8'h88);
        rd_chk(A_STAT, 8'h01);
        `CHK(evt_irq, 1'b0);
        wr(A_MASK, 8'h01);
        rd_chk(A_MASK, 8'h01);
        `CHK(evt_irq, 1'b1);
        wr(A_STAT, 8'h01);
        repeat (3) @(posedge ref_clk);
        `CHK(evt_irq, 1'b0);
        $display("test flag set done");
        // Every divide code: 2^n pulses give exactly one counter step
        for (int n = 0; n < 8; n++) begin
            wr(A_CTRL, 8'h08 | 8'(n));
            wr(A_PRESC, (n == 7) ? 8'h00 : 8'(1 << n));
            wr(A_COUNT, 8'h80);
            pulse(1 << n);
            rd_chk(A_COUNT, 8'h7F);
        end
        // Code 7 started from zero, so the prescaler reloaded once
        rd_chk(A_STAT, 8'h02);
        $display("test divide done");
        // Run off: prescaler forced, counter frozen
        wr(A_CTRL, 8'h00);
        rd_chk(A_PRESC, 8'h7F);
        pulse(3);
        rd_chk(A_COUNT, 8'h7F);
        $display("test stop done");
        // Gated mode counts the /12 tick only while the pin is high
        wr(A_CTRL, 8'h18);
        wr(A_PRESC, 8'h40);
        repeat (60) @(posedge ref_clk);
        rd_chk(A_PRESC, 8'h40);
        timer_pin_i <= 1'b1;
        repeat (60) @(posedge ref_clk);
        timer_pin_i <= 1'b0;
        repeat (4) @(posedge ref_clk);
        bus(1'b0, A_PRESC, 8'h00, 4'hF);
        d = 32'h40 - rd;
        `CHK(d >= 4 && d <= 6, 1'b1);
        $display("test gated done");
        // Output mode: pin latches the data bit at the flag rise only
        wr(A_CTRL, 8'h78);
        repeat (2) @(posedge ref_clk);
        `CHK(timer_pin_oe_n, 1'b0);
        `CHK(timer_pin_o, 1'b0);
        wr(A_COUNT, 8'h01);
        wait_irq();
        `CHK(timer_pin_o, 1'b1);
        wr(A_CTRL, 8'h68);
        repeat (3) @(posedge ref_clk);
        `CHK(timer_pin_o, 1'b1);
        wr(A_COUNT, 8'h01);
        wait_irq();
        `CHK(timer_pin_o, 1'b0);
        wr(A_CTRL, 8'h00);
        repeat (3) @(posedge ref_clk);
        `CHK(timer_pin_oe_n, 1'b1);
        $display("test output done");
        report_and_stop();
    end
endmodule // testbench
